// ==== splcs_map.svh ====
`ifndef SPLCS_MAP_SVH
`define SPLCS_MAP_SVH

// configuration space word offsets (24-bit byte addresses)
`define SPLCS_OFF_ERRSTAT 24'h000000
`define SPLCS_OFF_TIMEOUT 24'h000004
`define SPLCS_OFF_GENCTL 24'h000008
`define SPLCS_OFF_STATUS 24'h00000c

// error-and-status register fields
`define SPLCS_ES_UNINIT 0
`define SPLCS_ES_OK 1
`define SPLCS_ES_ERR 2
// general control: host bit
`define SPLCS_GC_HOST 31
// link status register fields
`define SPLCS_ST_LINKUP 0
`define SPLCS_ST_SINGLE 1
`define SPLCS_ST_REDUND 2
`define SPLCS_ST_IDLE 3
`define SPLCS_ST_MAINT 4

// reset values
`define SPLCS_TIMEOUT_RST 24'hffffff
`define SPLCS_HOST_RST 1'b0

// initialization thresholds
`define SPLCS_TX_STATUS_MIN 4'hf
`define SPLCS_RX_STATUS_MIN 4'h8
`define SPLCS_LRESET_MIN 3'h4

// silence timer before training, in ns, and its shortened form
`define SPLCS_CLK_NS 8
`define SPLCS_SILENCE_NS 1000
`define SPLCS_SILENCE_CYC \
    ((`SPLCS_SILENCE_NS + `SPLCS_CLK_NS - 1) / `SPLCS_CLK_NS)
`define SPLCS_SIM_SILENCE_CYC 8

`endif

// ==== splcs_pkg.sv ====
package splcs_pkg;

    // link initialization states
    typedef enum logic [2:0] {
        ST_SILENT,
        ST_TRAIN,
        ST_SYNC,
        ST_UP,
        ST_ERROR
    } splcs_state_e;

    // control symbol kinds carried on the symbol ports
    typedef enum logic [1:0] {
        SYM_STATUS,
        SYM_MCE,
        SYM_LRESET,
        SYM_OTHER
    } splcs_sym_e;

    typedef struct packed {
        logic valid;
        splcs_sym_e kind;
    } splcs_txsym_s;

    typedef struct packed {
        logic valid;
        logic err;
        splcs_sym_e kind;
    } splcs_rxsym_s;

endpackage : splcs_pkg

// ==== splcs_ctrl.sv ====
`timescale 1ns/1ps
`include "splcs_map.svh"

module splcs_ctrl (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic simTrainEn,
    input wire logic mceReq,
    input wire logic linkResetReq,
    input wire logic forceReinit,
    input wire logic trainSingleLane,
    input wire logic trainRedundant,
    input wire logic idleNegotiated,
    input wire logic unrecoverableErr,
    input wire splcs_pkg::splcs_rxsym_s rxSym,
    input wire logic rxIdle,
    output splcs_pkg::splcs_txsym_s txSym,
    output logic linkUp,
    output logic rcvdMce,
    output logic rcvdLinkReset,
    output logic portError,
    output logic portReady,
    output logic singleLaneMode,
    output logic idleChosen,
    output logic [23:0] portTimeout,
    output logic hostRole,
    output logic maintOnly,
    output logic redundantLane,
    input wire logic s_axi_cfgp_awvalid,
    output logic s_axi_cfgp_awready,
    input wire logic [23:0] s_axi_cfgp_awaddr,
    input wire logic s_axi_cfgp_wvalid,
    output logic s_axi_cfgp_wready,
    input wire logic [31:0] s_axi_cfgp_wdata,
    input wire logic [3:0] s_axi_cfgp_wstrb,
    output logic s_axi_cfgp_bvalid,
    input wire logic s_axi_cfgp_bready,
    output logic [1:0] s_axi_cfgp_bresp,
    input wire logic s_axi_cfgp_arvalid,
    output logic s_axi_cfgp_arready,
    input wire logic [23:0] s_axi_cfgp_araddr,
    output logic s_axi_cfgp_rvalid,
    input wire logic s_axi_cfgp_rready,
    output logic [31:0] s_axi_cfgp_rdata,
    output logic [1:0] s_axi_cfgp_rresp
);

    // byte-lane merge, used by the timeout and general control registers
    function automatic logic [31:0] splcs_merge(
        input logic [31:0] old,
        input logic [31:0] din,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = din[i*8 +: 8];
            end
        end
        return res;
    endfunction : splcs_merge

    localparam logic [7:0] SILENCE_CYC = 8'(`SPLCS_SILENCE_CYC);
    localparam logic [7:0] SIM_SILENCE_CYC = 8'(`SPLCS_SIM_SILENCE_CYC);

    splcs_pkg::splcs_state_e state_q;
    splcs_pkg::splcs_state_e state_d;
    splcs_pkg::splcs_txsym_s txSym_d;
    logic [7:0] timer_q;
    logic [3:0] txStatusCnt_q;
    logic [3:0] rxStatusCnt_q;
    logic [2:0] lrCnt_q;
    logic mcePend_q;
    logic errBit_q;
    logic [23:0] timeout_q;
    logic host_q;
    logic awHeld_q;
    logic wHeld_q;
    logic [23:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic doWrite;
    logic errClear;
    logic rxGood;
    logic lrHit;
    logic [31:0] rdMux;
    logic [7:0] silenceLimit;

    // sync may only advance to up once both sync thresholds are met
    logic syncDone;
    assign syncDone = (txStatusCnt_q >= `SPLCS_TX_STATUS_MIN) &&
        (rxStatusCnt_q >= `SPLCS_RX_STATUS_MIN);

    // shortened silence only for simulation runs
    assign silenceLimit = simTrainEn ? SIM_SILENCE_CYC : SILENCE_CYC;

    // initialization state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            splcs_pkg::ST_SILENT: begin
                if (timer_q >= silenceLimit) begin
                    state_d = splcs_pkg::ST_TRAIN;
                end
            end
            splcs_pkg::ST_TRAIN: begin
                if (idleNegotiated) begin
                    state_d = splcs_pkg::ST_SYNC;
                end
            end
            splcs_pkg::ST_SYNC: begin
                if (unrecoverableErr) begin
                    state_d = splcs_pkg::ST_ERROR;
                end else if (syncDone) begin
                    state_d = splcs_pkg::ST_UP;
                end
            end
            splcs_pkg::ST_UP: begin
                if (unrecoverableErr) begin
                    state_d = splcs_pkg::ST_ERROR;
                end
            end
            splcs_pkg::ST_ERROR: begin
                // software clearing the error bit restarts the link
                if (!errBit_q) begin
                    state_d = splcs_pkg::ST_SILENT;
                end
            end
            default: begin
                state_d = splcs_pkg::ST_SILENT;
            end
        endcase
        if (forceReinit) begin
            state_d = splcs_pkg::ST_SILENT;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= splcs_pkg::ST_SILENT;
        end else begin
            state_q <= state_d;
        end
    end

    // silence timer, restarted on every entry to silence
    always_ff @(posedge clk) begin
        if (!rst_b || state_q != splcs_pkg::ST_SILENT) begin
            timer_q <= 8'h00;
        end else if (timer_q < silenceLimit) begin
            timer_q <= timer_q + 8'h01;
        end
    end

    // transmit choice: link reset beats multicast beats status
    always_comb begin
        txSym_d.valid = 1'b0;
        txSym_d.kind = splcs_pkg::SYM_STATUS;
        if (linkResetReq) begin
            txSym_d.valid = 1'b1;
            txSym_d.kind = splcs_pkg::SYM_LRESET;
        end else if (mcePend_q || mceReq) begin
            txSym_d.valid = 1'b1;
            txSym_d.kind = splcs_pkg::SYM_MCE;
        end else if (state_q == splcs_pkg::ST_SYNC) begin
            txSym_d.valid = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            txSym <= '0;
        end else begin
            txSym <= txSym_d;
        end
    end

    // a request blocked by link reset waits here; new request wins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mcePend_q <= 1'b0;
        end else begin
            mcePend_q <= linkResetReq && (mceReq || mcePend_q);
        end
    end

    // sync counters, saturating, cleared outside sync
    assign rxGood = rxSym.valid && !rxSym.err;
    always_ff @(posedge clk) begin
        if (!rst_b || state_q != splcs_pkg::ST_SYNC) begin
            txStatusCnt_q <= 4'h0;
            rxStatusCnt_q <= 4'h0;
        end else begin
            if (txSym_d.valid && txSym_d.kind == splcs_pkg::SYM_STATUS &&
                txStatusCnt_q < `SPLCS_TX_STATUS_MIN) begin
                txStatusCnt_q <= txStatusCnt_q + 4'h1;
            end
            // an errored symbol breaks the error-free run
            if (rxSym.valid && rxSym.err) begin
                rxStatusCnt_q <= 4'h0;
            end else if (rxGood && rxSym.kind == splcs_pkg::SYM_STATUS &&
                rxStatusCnt_q < `SPLCS_RX_STATUS_MIN) begin
                rxStatusCnt_q <= rxStatusCnt_q + 4'h1;
            end
        end
    end

    // received link reset run; status and idles are transparent
    assign lrHit = rxGood && rxSym.kind == splcs_pkg::SYM_LRESET;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lrCnt_q <= 3'h0;
        end else if (lrHit) begin
            if (lrCnt_q == `SPLCS_LRESET_MIN - 3'h1) begin
                lrCnt_q <= 3'h0;
            end else begin
                lrCnt_q <= lrCnt_q + 3'h1;
            end
        end else if (rxIdle ||
            (rxGood && rxSym.kind == splcs_pkg::SYM_STATUS)) begin
            lrCnt_q <= lrCnt_q;
        end else if (rxSym.valid) begin
            lrCnt_q <= 3'h0;
        end
    end

    // received event pulses
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rcvdMce <= 1'b0;
            rcvdLinkReset <= 1'b0;
        end else begin
            rcvdMce <= rxGood && rxSym.kind == splcs_pkg::SYM_MCE;
            rcvdLinkReset <= lrHit &&
                lrCnt_q == `SPLCS_LRESET_MIN - 3'h1;
        end
    end

    // training results, sampled as sync begins
    always_ff @(posedge clk) begin
        if (!rst_b || state_q == splcs_pkg::ST_SILENT) begin
            singleLaneMode <= 1'b0;
            redundantLane <= 1'b0;
            idleChosen <= 1'b0;
        end else if (state_q == splcs_pkg::ST_TRAIN && idleNegotiated) begin
            singleLaneMode <= trainSingleLane;
            redundantLane <= trainRedundant;
            idleChosen <= 1'b1;
        end
    end

    // write channel: address and data taken independently
    assign s_axi_cfgp_awready = !awHeld_q && !s_axi_cfgp_bvalid;
    assign s_axi_cfgp_wready = !wHeld_q && !s_axi_cfgp_bvalid;
    assign doWrite = awHeld_q && wHeld_q && !s_axi_cfgp_bvalid;
    assign s_axi_cfgp_bresp = 2'h0;
    assign s_axi_cfgp_rresp = 2'h0;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            awHeld_q <= 1'b0;
            awAddr_q <= 24'h000000;
        end else if (s_axi_cfgp_awvalid && s_axi_cfgp_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_cfgp_awaddr;
        end else if (doWrite) begin
            awHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wHeld_q <= 1'b0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
        end else if (s_axi_cfgp_wvalid && s_axi_cfgp_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_cfgp_wdata;
            wStrb_q <= s_axi_cfgp_wstrb;
        end else if (doWrite) begin
            wHeld_q <= 1'b0;
        end
    end

    // response stays up until the master takes it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_axi_cfgp_bvalid <= 1'b0;
        end else if (doWrite) begin
            s_axi_cfgp_bvalid <= 1'b1;
        end else if (s_axi_cfgp_bready) begin
            s_axi_cfgp_bvalid <= 1'b0;
        end
    end

    // merged words held as nets, since a call result cannot be sliced
    logic [31:0] toMerged;
    logic [31:0] gcMerged;
    assign toMerged = splcs_merge({8'h00, timeout_q}, wData_q, wStrb_q);
    assign gcMerged = splcs_merge({host_q, 31'h0}, wData_q, wStrb_q);

    // writable fields
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            timeout_q <= `SPLCS_TIMEOUT_RST;
            host_q <= `SPLCS_HOST_RST;
        end else if (doWrite) begin
            if (awAddr_q == `SPLCS_OFF_TIMEOUT) begin
                timeout_q <= toMerged[23:0];
            end
            if (awAddr_q == `SPLCS_OFF_GENCTL) begin
                host_q <= gcMerged[`SPLCS_GC_HOST];
            end
        end
    end

    // error bit: write one to clear, a new error wins
    assign errClear = doWrite && awAddr_q == `SPLCS_OFF_ERRSTAT &&
        wStrb_q[0] && wData_q[`SPLCS_ES_ERR];
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            errBit_q <= 1'b0;
        end else if (state_d == splcs_pkg::ST_ERROR &&
            state_q != splcs_pkg::ST_ERROR) begin
            errBit_q <= 1'b1;
        end else if (errClear) begin
            errBit_q <= 1'b0;
        end
    end

    // read mux; unmapped words read as zero
    always_comb begin
        rdMux = 32'h00000000;
        case (s_axi_cfgp_araddr)
            `SPLCS_OFF_ERRSTAT: begin
                rdMux[`SPLCS_ES_UNINIT] = state_q != splcs_pkg::ST_UP;
                rdMux[`SPLCS_ES_OK] = state_q == splcs_pkg::ST_UP;
                rdMux[`SPLCS_ES_ERR] = errBit_q;
            end
            `SPLCS_OFF_TIMEOUT: rdMux[23:0] = timeout_q;
            `SPLCS_OFF_GENCTL: rdMux[`SPLCS_GC_HOST] = host_q;
            `SPLCS_OFF_STATUS: begin
                rdMux[`SPLCS_ST_LINKUP] = linkUp;
                rdMux[`SPLCS_ST_SINGLE] = singleLaneMode;
                rdMux[`SPLCS_ST_REDUND] = redundantLane;
                rdMux[`SPLCS_ST_IDLE] = idleChosen;
                rdMux[`SPLCS_ST_MAINT] = maintOnly;
            end
            default: rdMux = 32'h00000000;
        endcase
    end

    // one read outstanding; data frozen while valid
    assign s_axi_cfgp_arready = !s_axi_cfgp_rvalid;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_axi_cfgp_rvalid <= 1'b0;
            s_axi_cfgp_rdata <= 32'h00000000;
        end else if (s_axi_cfgp_arvalid && s_axi_cfgp_arready) begin
            s_axi_cfgp_rvalid <= 1'b1;
            s_axi_cfgp_rdata <= rdMux;
        end else if (s_axi_cfgp_rready) begin
            s_axi_cfgp_rvalid <= 1'b0;
        end
    end

    // registered status mirrors, all inactive during reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            linkUp <= 1'b0;
            portError <= 1'b0;
            portReady <= 1'b0;
            portTimeout <= 24'h000000;
            hostRole <= 1'b0;
            maintOnly <= 1'b0;
        end else begin
            linkUp <= state_q == splcs_pkg::ST_UP;
            portError <= errBit_q;
            portReady <= state_q == splcs_pkg::ST_UP;
            portTimeout <= timeout_q;
            hostRole <= host_q;
            // far side must stick to maintenance while in error
            maintOnly <= errBit_q;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    mce_send_a: assert property (mceReq && !linkResetReq |=>
        txSym.valid && txSym.kind == splcs_pkg::SYM_MCE)
        else $error("multicast request not sent");
    lreset_hold_a: assert property (linkResetReq |=>
        txSym.valid && txSym.kind == splcs_pkg::SYM_LRESET)
        else $error("link reset not sent while held");
    lreset_stop_a: assert property (!linkResetReq |=>
        txSym.kind != splcs_pkg::SYM_LRESET || !txSym.valid)
        else $error("link reset sent after release");
    reinit_a: assert property (forceReinit |=>
        state_q == splcs_pkg::ST_SILENT ##1 !linkUp)
        else $error("reinit did not restart link");
    link_up_a: assert property ($rose(linkUp) |->
        $past(txStatusCnt_q, 2) == `SPLCS_TX_STATUS_MIN &&
        $past(rxStatusCnt_q, 2) == `SPLCS_RX_STATUS_MIN)
        else $error("link up before status counts met");
    rx_mce_a: assert property (rxGood &&
        rxSym.kind == splcs_pkg::SYM_MCE |=> rcvdMce)
        else $error("received multicast not flagged");
    rx_lreset_a: assert property (rcvdLinkReset |->
        $past(lrCnt_q) == `SPLCS_LRESET_MIN - 3'h1 && lrCnt_q == 3'h0)
        else $error("link reset flagged early");
    lr_keep_a: assert property (rxIdle && !rxSym.valid |=>
        lrCnt_q == $past(lrCnt_q))
        else $error("idle broke link reset count");
    port_err_a: assert property (state_q == splcs_pkg::ST_ERROR ##1
        state_q == splcs_pkg::ST_ERROR |-> portError)
        else $error("port error not shown in error state");
    port_rdy_a: assert property (portReady |-> linkUp &&
        $past(state_q) == splcs_pkg::ST_UP)
        else $error("port ready without initialization");
    bvalid_hold_a: assert property (s_axi_cfgp_bvalid &&
        !s_axi_cfgp_bready |=> s_axi_cfgp_bvalid)
        else $error("write response dropped");
    rvalid_hold_a: assert property (s_axi_cfgp_rvalid &&
        !s_axi_cfgp_rready |=> s_axi_cfgp_rvalid &&
        $stable(s_axi_cfgp_rdata))
        else $error("read response dropped or changed");

    link_up_c: cover property ($rose(linkUp));
    rx_lreset_c: cover property (rcvdLinkReset);
    mce_c: cover property (txSym.valid &&
        txSym.kind == splcs_pkg::SYM_MCE);
    write_c: cover property (s_axi_cfgp_bvalid && s_axi_cfgp_bready);

endmodule : splcs_ctrl

// ==== splcs_partner.sv ====
`timescale 1ns/1ps
// far link partner: status stream, injected symbols, idle fill
module splcs_partner (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic statusOn,
    input wire logic injValid,
    input wire logic injErr,
    input wire splcs_pkg::splcs_sym_e injKind,
    output splcs_pkg::splcs_rxsym_s rxSym,
    output logic rxIdle
);
    logic flip_q;

    // free toggle so unused fields never sit still
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flip_q <= 1'b0;
        end else begin
            flip_q <= !flip_q;
        end
    end

    // an injected symbol wins over the status stream
    always_comb begin
        rxSym = {1'b0, flip_q, flip_q, !flip_q};
        rxIdle = 1'b0;
        if (injValid) begin
            rxSym = {1'b1, injErr, injKind};
        end else if (statusOn) begin
            rxSym = {2'b10, splcs_pkg::SYM_STATUS};
        end else begin
            rxIdle = flip_q;
        end
    end
endmodule : splcs_partner

// ==== splcs_ctrl_test.sv ====
`timescale 1ns/1ps
`include "splcs_map.svh"
module splcs_ctrl_test;
    logic clk, rst_b, simTrainEn, mceReq, linkResetReq, forceReinit;
    logic trainSingleLane, trainRedundant, idleNegotiated;
    logic unrecoverableErr, statusOn, injValid, injErr, rxIdle;
    splcs_pkg::splcs_sym_e injKind;
    splcs_pkg::splcs_rxsym_s rxSym;
    splcs_pkg::splcs_txsym_s txSym;
    logic linkUp, rcvdMce, rcvdLinkReset, portError, portReady;
    logic singleLaneMode, idleChosen, hostRole, maintOnly, redundantLane;
    logic [23:0] portTimeout, awAddr, arAddr;
    logic awValid, awReady, wValid, wReady, bValid, bReady;
    logic arValid, arReady, rValid, rReady;
    logic [31:0] wData, rData, rd;
    logic [3:0] wStrb;
    logic [1:0] bResp, rResp;
    int failures, check_count, statusSent;

    // 125 MHz
    initial clk = 1'b0;
    always #4 clk = !clk;

    splcs_ctrl i_dut (.clk(clk), .rst_b(rst_b), .simTrainEn(simTrainEn),
        .mceReq(mceReq), .linkResetReq(linkResetReq),
        .forceReinit(forceReinit), .trainSingleLane(trainSingleLane),
        .trainRedundant(trainRedundant), .idleNegotiated(idleNegotiated),
        .unrecoverableErr(unrecoverableErr), .rxSym(rxSym),
        .rxIdle(rxIdle), .txSym(txSym), .linkUp(linkUp),
        .rcvdMce(rcvdMce), .rcvdLinkReset(rcvdLinkReset),
        .portError(portError), .portReady(portReady),
        .singleLaneMode(singleLaneMode), .idleChosen(idleChosen),
        .portTimeout(portTimeout), .hostRole(hostRole),
        .maintOnly(maintOnly), .redundantLane(redundantLane),
        .s_axi_cfgp_awvalid(awValid), .s_axi_cfgp_awready(awReady),
        .s_axi_cfgp_awaddr(awAddr), .s_axi_cfgp_wvalid(wValid),
        .s_axi_cfgp_wready(wReady), .s_axi_cfgp_wdata(wData),
        .s_axi_cfgp_wstrb(wStrb), .s_axi_cfgp_bvalid(bValid),
        .s_axi_cfgp_bready(bReady), .s_axi_cfgp_bresp(bResp),
        .s_axi_cfgp_arvalid(arValid), .s_axi_cfgp_arready(arReady),
        .s_axi_cfgp_araddr(arAddr), .s_axi_cfgp_rvalid(rValid),
        .s_axi_cfgp_rready(rReady), .s_axi_cfgp_rdata(rData),
        .s_axi_cfgp_rresp(rResp));

    splcs_partner i_partner (.clk(clk), .rst_b(rst_b),
        .statusOn(statusOn), .injValid(injValid), .injErr(injErr),
        .injKind(injKind), .rxSym(rxSym), .rxIdle(rxIdle));

    // status symbols sent since reset or the last forced reinit
    always @(posedge clk) begin
        if (!rst_b || forceReinit) begin
            statusSent <= 0;
        end else if (txSym.valid && txSym.kind == splcs_pkg::SYM_STATUS) begin
            statusSent <= statusSent + 1;
        end
    end

    task end_sim;
        $display("failures %0d checks %0d", failures, check_count);
        if (failures == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task timeout;
        failures++;
        $display("[ERR] %0t wait ran out", $time);
        end_sim;
    endtask : timeout

    function automatic logic [31:0] txw(splcs_pkg::splcs_sym_e k);
        return {29'h0, 1'b1, k};
    endfunction : txw

    // write: both channels offered together, bready held throughout
    task axw(input logic [23:0] a, input logic [31:0] d, input logic [3:0] s);
        logic done;
        done = 1'b0;
        @(posedge clk);
        awValid <= 1'b1; wValid <= 1'b1; bReady <= 1'b1;
        awAddr <= a; wData <= d; wStrb <= s;
        for (int n = 0; n < 20 && !done; n++) begin
            @(posedge clk);
            if (awValid && awReady) awValid <= 1'b0;
            if (wValid && wReady) wValid <= 1'b0;
            if (bValid === 1'b1) begin
                check(32'(bResp), 32'h0);
                done = 1'b1;
            end
        end
        bReady <= 1'b0;
        if (!done) timeout();
        #1;
    endtask : axw

    // read: data taken at the edge where rvalid meets rready
    task axr(input logic [23:0] a, output logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge clk);
        arValid <= 1'b1; arAddr <= a; rReady <= 1'b1;
        for (int n = 0; n < 20 && !done; n++) begin
            @(posedge clk);
            if (arValid && arReady) arValid <= 1'b0;
            if (rValid === 1'b1) begin
                check(32'(rResp), 32'h0);
                d = rData;
                done = 1'b1;
            end
        end
        rReady <= 1'b0;
        if (!done) timeout();
        #1;
    endtask : axr

    task wait_up(input int lim);
        for (int n = 0; n < lim && linkUp !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (linkUp !== 1'b1) timeout();
    endtask : wait_up

    // one symbol from the partner; rcvd flags settle on return
    task rx1(input splcs_pkg::splcs_sym_e k, input logic e);
        @(posedge clk);
        injValid <= 1'b1; injKind <= k; injErr <= e;
        @(posedge clk);
        injValid <= 1'b0;
        #1;
    endtask : rx1

    // byte strobes, read-back, mirrors, unmapped read
    task t_regs;
        axr(`SPLCS_OFF_TIMEOUT, rd);
        check(rd, {8'h0, `SPLCS_TIMEOUT_RST});
        axw(`SPLCS_OFF_TIMEOUT, 32'hab123456, 4'h5);
        axr(`SPLCS_OFF_TIMEOUT, rd);
        check(rd, 32'h0012ff56);
        check({8'h0, portTimeout}, 32'h0012ff56);
        axw(`SPLCS_OFF_GENCTL, 32'h80000000, 4'h8);
        axw(`SPLCS_OFF_GENCTL, 32'h0, 4'h7);
        check(32'(hostRole), 32'h1);
        axr(`SPLCS_OFF_GENCTL, rd);
        check(rd, 32'h80000000);
        axr(24'h000010, rd);
        check(rd, 32'h0);
    endtask : t_regs

    // mce asked during a link reset burst waits, then goes once
    task t_tx;
        @(posedge clk);
        mceReq <= 1'b1; linkResetReq <= 1'b1;
        @(posedge clk);
        mceReq <= 1'b0;
        #1 check({29'h0, txSym}, txw(splcs_pkg::SYM_LRESET));
        @(posedge clk);
        #1 check({29'h0, txSym}, txw(splcs_pkg::SYM_LRESET));
        @(posedge clk);
        linkResetReq <= 1'b0;
        #1 check({29'h0, txSym}, txw(splcs_pkg::SYM_LRESET));
        @(posedge clk);
        #1 check({29'h0, txSym}, txw(splcs_pkg::SYM_MCE));
        @(posedge clk);
        #1 check(32'(txSym.valid), 32'h0);
    endtask : t_tx

    // training with 1x and redundancy lane results
    task t_up;
        @(posedge clk);
        trainSingleLane <= 1'b1; trainRedundant <= 1'b1;
        statusOn <= 1'b1; idleNegotiated <= 1'b1;
        wait_up(100);
        check(32'(statusSent >= 15), 32'h1);
        check(32'(singleLaneMode), 32'h1);
        check(32'(redundantLane), 32'h1);
        check(32'(idleChosen), 32'h1);
        check(32'(portReady), 32'h1);
    endtask : t_up

    // received mce and link reset runs with interruptions
    task t_rx;
        rx1(splcs_pkg::SYM_MCE, 1'b0);
        check(32'(rcvdMce), 32'h1);
        rx1(splcs_pkg::SYM_LRESET, 1'b0);
        check(32'(rcvdMce), 32'h0);
        rx1(splcs_pkg::SYM_STATUS, 1'b0);
        rx1(splcs_pkg::SYM_LRESET, 1'b0);
        rx1(splcs_pkg::SYM_LRESET, 1'b0);
        check(32'(rcvdLinkReset), 32'h0);
        rx1(splcs_pkg::SYM_LRESET, 1'b0);
        check(32'(rcvdLinkReset), 32'h1);
        rx1(splcs_pkg::SYM_OTHER, 1'b0);
        rx1(splcs_pkg::SYM_LRESET, 1'b0);
        rx1(splcs_pkg::SYM_LRESET, 1'b1);
        for (int i = 0; i < 4; i++) begin
            rx1(splcs_pkg::SYM_LRESET, 1'b0);
            check(32'(rcvdLinkReset), 32'(i == 3));
        end
    endtask : t_rx

    // forced restart drops the link; short timers bring it back fast
    task t_reinit;
        @(posedge clk);
        trainSingleLane <= 1'b0; trainRedundant <= 1'b0;
        forceReinit <= 1'b1;
        @(posedge clk);
        forceReinit <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check(32'(linkUp), 32'h0);
        wait_up(60);
        check(32'(singleLaneMode), 32'h0);
        check(32'(redundantLane), 32'h0);
    endtask : t_reinit

    // fatal error, maintenance restriction, clear by writing one
    task t_err;
        @(posedge clk);
        unrecoverableErr <= 1'b1;
        @(posedge clk);
        unrecoverableErr <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check(32'(portError), 32'h1);
        check(32'(maintOnly), 32'h1);
        check(32'(portReady), 32'h0);
        axr(`SPLCS_OFF_ERRSTAT, rd);
        check(32'(rd[`SPLCS_ES_ERR]), 32'h1);
        axw(`SPLCS_OFF_ERRSTAT, 32'h4, 4'h1);
        repeat (2) @(posedge clk);
        #1 check(32'(portError), 32'h0);
        check(32'(maintOnly), 32'h0);
        wait_up(60);
    endtask : t_err

    // full silence timer when simulation training is off
    task t_slow;
        @(posedge clk);
        simTrainEn <= 1'b0;
        forceReinit <= 1'b1;
        @(posedge clk);
        forceReinit <= 1'b0;
        repeat (100) @(posedge clk);
        #1 check(32'(linkUp), 32'h0);
        wait_up(100);
    endtask : t_slow

    // main sequence
    initial begin
        failures = 0;
        check_count = 0;
        rst_b = 1'b0;
        simTrainEn = 1'b1;
        {mceReq, linkResetReq, forceReinit, trainSingleLane} = '0;
        {trainRedundant, idleNegotiated, unrecoverableErr} = '0;
        {statusOn, injValid, injErr} = '0;
        {awValid, wValid, bReady, arValid, rReady} = '0;
        injKind = splcs_pkg::SYM_OTHER;
        awAddr = '0; arAddr = '0; wData = '0; wStrb = '0;
        repeat (2) @(posedge clk);
        #1 check({22'h0, linkUp, rcvdMce, rcvdLinkReset, portError,
            portReady, singleLaneMode, idleChosen, hostRole, maintOnly,
            redundantLane}, 32'h0);
        check({8'h0, portTimeout}, 32'h0);
        @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check({8'h0, portTimeout}, {8'h0, `SPLCS_TIMEOUT_RST});
        t_regs();
        t_tx();
        t_up();
        t_rx();
        t_reinit();
        t_err();
        t_slow();
        end_sim();
    end
endmodule : splcs_ctrl_test
